// file: design/nib_core.sv
// The implementer's own choices: the Avalon-MM slave port and the placing of the registers.
`timescale 1ns/1ps
module nib_core
  import nib_pkg::*;
#(
  parameter int PC_W = 11
)(
  // Clock and reset
  input  wire logic              i_clk,
  input  wire logic              i_rst_n,
  // Instruction issue
  input  wire logic              i_ins_valid,
  input  wire logic [15:0]       i_ins_word,
  input  wire logic [15:0]       i_ins_next,
  output logic                   o_ins_ready,
  // Program memory read
  output logic                   o_rom_rd,
  output logic [11:0]            o_rom_addr,
  input  wire logic              i_rom_valid,
  input  wire logic [9:0]        i_rom_data,
  // Status inputs for test and wake
  input  wire logic [3:0]        i_status,
  // Avalon-MM slave
  input  wire logic [7:0]        i_address,
  input  wire logic              i_read,
  input  wire logic              i_write,
  input  wire logic [3:0]        i_byteenable,
  input  wire logic [31:0]       i_writedata,
  output logic [31:0]            o_readdata,
  output logic                   o_waitrequest,
  // Visible state
  output logic [3:0]             o_acc,
  output logic                   o_carry,
  output logic                   o_match,
  output logic                   o_standby,
  output logic [9:0]             o_timer,
  output logic [PC_W-1:0]        o_pc
);

  if (PC_W < 4 || PC_W > 16) begin : g_bad_pc
    $error("PC_W must be 4 to 16");
  end

  typedef struct packed {
    fsm_t             fsm;
    logic [3:0]       acc;
    logic             cy;
    logic             match;
    logic             stby;
    logic [3:0]       wake_mask;
    logic [9:0]       timer;
    logic [3:0]       page;
    logic [PC_W-1:0]  pc;
    logic [15:0]      pend;
    logic [15:0][3:0] bank0;
    logic [15:0][3:0] bank1;
    logic             waitreq;
    logic [31:0]      rdata;
    logic             ins_ready;
    logic             rom_rd;
    logic [11:0]      rom_addr;
  } core_t;

  core_t   s_r;
  core_t   s_nxt;
  logic    rst_n;
  lu_in_t  lu_in;
  lu_out_t lu_out;

  // Logic opcode test, used by issue decode; operand select uses grp_op alone
  function automatic logic is_logic(input logic [7:0] hi);
    logic [3:0] g;
    g = hi[4:1];
    is_logic = (hi[7:5] == HI_TOP) &&
               (g == GRP_AND || g == GRP_OR || g == GRP_XOR);
  endfunction : is_logic

  function automatic lop_t grp_op(input logic [7:0] hi);
    case (hi[4:1])
      GRP_AND: grp_op = LOP_AND;
      GRP_OR:  grp_op = LOP_OR;
      default: grp_op = LOP_XOR;
    endcase
  endfunction : grp_op

  // Register read mux; unmapped offsets read zero
  function automatic logic [31:0] reg_read(input core_t s, input logic [7:0] a);
    logic [31:0] d;
    d = '0;
    if (a[7:6] == REG_PAIRS) begin
      d[7:0] = {s.bank1[a[5:2]], s.bank0[a[5:2]]};
    end else begin
      case (a)
        REG_CTRL: d[CTRL_PAGE +: 4] = s.page;
        REG_STATE: begin
          d[3:0]     = s.acc;
          d[ST_CY]    = s.cy;
          d[ST_MATCH] = s.match;
          d[ST_STBY]  = s.stby;
          d[ST_BUSY]  = (s.fsm == S_ROM);
        end
        REG_TIMER: d[9:0] = s.timer;
        REG_PC:    d[PC_W-1:0] = s.pc;
        REG_ACC:   d[4:0] = {s.cy, s.acc};
        default:   d = '0;
      endcase
    end
    reg_read = d;
  endfunction : reg_read

  rst_sync u_rst (
    .i_clk   (i_clk),
    .i_rst_n (i_rst_n),
    .o_rst_n (rst_n)
  );

  // Operand select: memory nibble while waiting, else register or immediate
  always_comb begin
    lu_in.a  = s_r.acc;
    lu_in.op = grp_op(i_ins_word[15:8]);
    if (i_ins_word[7:0] == LO_IMM) begin
      lu_in.b = i_ins_next[3:0];
    end else if (i_ins_word[8]) begin
      lu_in.b = s_r.bank0[i_ins_word[3:0]];
    end else begin
      lu_in.b = s_r.bank1[i_ins_word[3:0]];
    end
    if (s_r.fsm == S_ROM) begin
      lu_in.op = grp_op(s_r.pend[15:8]);
      // One opcode bit picks the nibble
      lu_in.b  = s_r.pend[8] ? i_rom_data[3:0] : i_rom_data[7:4];
    end
  end

  nib_logic u_logic (
    .i_in  (lu_in),
    .o_out (lu_out)
  );

  // Whole next state
  always_comb begin
    logic [7:0] hi;
    logic [7:0] lo;
    logic       take;
    hi    = i_ins_word[15:8];
    lo    = i_ins_word[7:0];
    take  = i_ins_valid && s_r.ins_ready;
    s_nxt = s_r;
    s_nxt.rom_rd = 1'b0;

    // Bus: one cycle of waitrequest low per request
    s_nxt.waitreq = 1'b1;
    if ((i_read || i_write) && s_r.waitreq) begin
      s_nxt.waitreq = 1'b0;
      s_nxt.rdata   = reg_read(s_r, i_address);
    end

    // Software writes land on the completing edge only
    if (i_write && !s_r.waitreq && i_byteenable[0]) begin
      if (i_address[7:6] == REG_PAIRS) begin
        s_nxt.bank1[i_address[5:2]] = i_writedata[7:4];
        s_nxt.bank0[i_address[5:2]] = i_writedata[3:0];
      end else begin
        case (i_address)
          REG_CTRL: begin
            s_nxt.page = i_writedata[CTRL_PAGE +: 4];
            if (i_writedata[CTRL_WAKE]) begin
              s_nxt.stby = 1'b0;
            end
          end
          REG_TIMER: begin
            if (i_byteenable[1]) begin
              s_nxt.timer = i_writedata[9:0];
            end
          end
          REG_ACC: begin
            s_nxt.acc = i_writedata[3:0];
            s_nxt.cy  = i_writedata[4];
          end
          default: begin
            s_nxt.rdata = s_nxt.rdata;
          end
        endcase
      end
    end

    // A selected status input going active ends standby
    if (s_r.stby && |(i_status & s_r.wake_mask)) begin
      s_nxt.stby = 1'b0;
    end

    case (s_r.fsm)
      S_IDLE: begin
        if (take) begin
          s_nxt.pc = s_r.pc + PC_W'(1);
          if (is_logic(hi) && lo[7:4] == LO_REG) begin
            // Register operand, single word
            s_nxt.acc = lu_out.res;
            s_nxt.cy  = lu_out.cy;
          end else if (is_logic(hi) && lo == LO_IMM) begin
            s_nxt.acc = lu_out.res;
            s_nxt.cy  = lu_out.cy;
            s_nxt.pc  = s_r.pc + PC_W'(2);
          end else if ((is_logic(hi) && lo == LO_IND) || i_ins_word == OP_T_IND) begin
            // Memory word at page and first pair; result when it returns
            s_nxt.rom_rd   = 1'b1;
            s_nxt.rom_addr = {s_r.page, s_r.bank1[0], s_r.bank0[0]};
            s_nxt.pend     = i_ins_word;
            s_nxt.fsm      = S_ROM;
          end else if (hi == OP_TEST_REG && lo[7:4] == LO_REG) begin
            s_nxt.match = |(i_status & s_r.bank0[lo[3:0]]);
          end else begin
            case (i_ins_word)
              OP_A_FROM_T0: begin
                s_nxt.acc = s_r.timer[3:0];
                s_nxt.cy  = 1'b0;
              end
              OP_A_FROM_T1: begin
                s_nxt.acc = s_r.timer[7:4];
                s_nxt.cy  = 1'b0;
              end
              OP_T0_FROM_A: s_nxt.timer[3:0] = s_r.acc;
              OP_T1_FROM_A: s_nxt.timer[7:4] = s_r.acc;
              OP_T_IMM: begin
                s_nxt.timer = i_ins_next[9:0];
                s_nxt.pc    = s_r.pc + PC_W'(2);
              end
              OP_STANDBY: begin
                s_nxt.stby      = 1'b1;
                s_nxt.wake_mask = i_ins_next[3:0];
                s_nxt.pc        = s_r.pc + PC_W'(2);
              end
              OP_TEST_IMM: begin
                s_nxt.match = |(i_status & i_ins_next[3:0]);
                s_nxt.pc    = s_r.pc + PC_W'(2);
              end
              OP_CARRY15: s_nxt.cy = (s_r.acc == NIB_15);
              default: s_nxt.pc = s_r.pc + PC_W'(1);
            endcase
          end
        end
      end
      S_ROM: begin
        if (i_rom_valid) begin
          s_nxt.fsm = S_IDLE;
          if (s_r.pend == OP_T_IND) begin
            s_nxt.timer = i_rom_data;
          end else begin
            s_nxt.acc = lu_out.res;
            s_nxt.cy  = lu_out.cy;
          end
        end
      end
      default: s_nxt.fsm = S_IDLE;
    endcase

    // Issue port closes while memory is awaited or in standby
    s_nxt.ins_ready = (s_nxt.fsm == S_IDLE) && !s_nxt.stby;
  end

  // State register; waitrequest idles high so no request completes in reset
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_r         <= '0;
      s_r.fsm     <= S_IDLE;
      s_r.acc     <= ACC_RST;
      s_r.timer   <= TIMER_RST;
      s_r.page    <= PAGE_RST;
      s_r.waitreq <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  // Outputs straight from the state register
  assign o_ins_ready   = s_r.ins_ready;
  assign o_rom_rd      = s_r.rom_rd;
  assign o_rom_addr    = s_r.rom_addr;
  assign o_readdata    = s_r.rdata;
  assign o_waitrequest = s_r.waitreq;
  assign o_acc         = s_r.acc;
  assign o_carry       = s_r.cy;
  assign o_match       = s_r.match;
  assign o_standby     = s_r.stby;
  assign o_timer       = s_r.timer;
  assign o_pc          = s_r.pc;

endmodule : nib_core

// file: design/nib_pkg.sv
package nib_pkg;

  // Opcodes as whole words; OP_TEST_REG is a high byte only
  localparam logic [15:0] OP_A_FROM_T0 = 16'hffff;
  localparam logic [15:0] OP_A_FROM_T1 = 16'hfeff;
  localparam logic [15:0] OP_T0_FROM_A = 16'he5ff;
  localparam logic [15:0] OP_T1_FROM_A = 16'he4ff;
  localparam logic [15:0] OP_T_IMM     = 16'he6ff;
  localparam logic [15:0] OP_T_IND     = 16'hf4ff;
  localparam logic [15:0] OP_STANDBY   = 16'he2f1;
  localparam logic [15:0] OP_TEST_IMM  = 16'he3f1;
  localparam logic [15:0] OP_CARRY15   = 16'hfaf3;
  localparam logic [15:0] OP_NOP       = 16'he0e0;
  localparam logic [7:0]  OP_TEST_REG  = 8'he3;

  // Logic opcode fields: high byte 111 grp form, low byte kind
  localparam logic [2:0]  HI_TOP   = 3'h7;
  localparam logic [3:0]  GRP_AND  = 4'hd;
  localparam logic [3:0]  GRP_OR   = 4'he;
  localparam logic [3:0]  GRP_XOR  = 4'ha;
  localparam logic [3:0]  LO_REG   = 4'he;
  localparam logic [7:0]  LO_IND   = 8'hf0;
  localparam logic [7:0]  LO_IMM   = 8'hf1;
  localparam logic [3:0]  NIB_15   = 4'hf;

  // Avalon register byte offsets
  localparam logic [7:0]  REG_CTRL  = 8'h00;
  localparam logic [7:0]  REG_STATE = 8'h04;
  localparam logic [7:0]  REG_TIMER = 8'h08;
  localparam logic [7:0]  REG_PC    = 8'h0c;
  localparam logic [7:0]  REG_ACC   = 8'h10;
  localparam logic [1:0]  REG_PAIRS = 2'h1;

  // Field positions
  localparam int CTRL_WAKE  = 0;
  localparam int CTRL_PAGE  = 4;
  localparam int ST_CY      = 4;
  localparam int ST_MATCH   = 5;
  localparam int ST_STBY    = 6;
  localparam int ST_BUSY    = 7;

  // Reset values
  localparam logic [3:0] ACC_RST   = 4'h0;
  localparam logic [9:0] TIMER_RST = 10'h000;
  localparam logic [3:0] PAGE_RST  = 4'h0;

  typedef enum logic [1:0] {LOP_AND, LOP_OR, LOP_XOR} lop_t;
  typedef enum logic {S_IDLE, S_ROM} fsm_t;

  typedef struct packed {
    lop_t       op;
    logic [3:0] a;
    logic [3:0] b;
  } lu_in_t;

  typedef struct packed {
    logic [3:0] res;
    logic       cy;
  } lu_out_t;

endpackage : nib_pkg

// file: design/rst_sync.sv
`timescale 1ns/1ps
module rst_sync
  import nib_pkg::*;
(
  // Clock and raw reset
  input  wire logic i_clk,
  input  wire logic i_rst_n,
  // Released reset
  output wire logic o_rst_n
);

  typedef struct packed {
    logic meta;
    logic sync;
  } sync_t;

  sync_t s_r;
  sync_t s_nxt;

  // Shift a one in; assertion is immediate, release takes two edges
  always_comb begin
    s_nxt.meta = 1'b1;
    s_nxt.sync = s_r.meta;
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign o_rst_n = s_r.sync;

endmodule : rst_sync

// file: design/nib_logic.sv
`timescale 1ns/1ps
module nib_logic
  import nib_pkg::*;
(
  // Operands
  input  wire lu_in_t  i_in,
  // Result
  output lu_out_t      o_out
);

  // Carry for AND and XOR is taken from the top bits of both incoming operands, never the result; OR clears it
  always_comb begin
    o_out = '0;
    case (i_in.op)
      LOP_AND: begin
        o_out.res = i_in.a & i_in.b;
        o_out.cy  = i_in.a[3] & i_in.b[3];
      end
      LOP_OR: begin
        o_out.res = i_in.a | i_in.b;
        o_out.cy  = 1'b0;
      end
      LOP_XOR: begin
        o_out.res = i_in.a ^ i_in.b;
        o_out.cy  = i_in.a[3] & i_in.b[3];
      end
      default: begin
        o_out = '0;
      end
    endcase
  end

endmodule : nib_logic

// file: tb/nib_core_assertions.sv
`timescale 1ns/1ps
module nib_core_assertions
  import nib_pkg::*;
#(
  parameter int PC_W = 11
)(
  // Clock, reset, instruction issue and status inputs
  input wire logic            i_clk,
  input wire logic            i_rst_n,
  input wire logic            i_ins_valid,
  input wire logic [15:0]     i_ins_word,
  input wire logic [15:0]     i_ins_next,
  input wire logic            o_ins_ready,
  input wire logic [3:0]      i_status,
  // Visible state
  input wire logic [3:0]      o_acc,
  input wire logic            o_carry,
  input wire logic            o_match,
  input wire logic            o_standby,
  input wire logic [9:0]      o_timer,
  input wire logic [PC_W-1:0] o_pc
);
  // Accepted word and its immediate nibble
  wire logic        go  = i_ins_valid && o_ins_ready;
  wire logic [15:0] w   = i_ins_word;
  wire logic [3:0]  nib = i_ins_next[3:0];

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  a_timer_to_acc: assert property (
    go && w == OP_A_FROM_T1 |=> o_acc == $past(o_timer[7:4]) && !o_carry)
    else $error("timer nibble not copied to accumulator");
  a_acc_to_timer: assert property (
    go && w == OP_T0_FROM_A |=> o_timer[3:0] == $past(o_acc))
    else $error("accumulator not copied to timer");
  a_timer_imm: assert property (
    go && w == OP_T_IMM |=> o_timer == $past(i_ins_next[9:0]))
    else $error("timer not loaded from immediate");
  a_standby_entry: assert property (
    go && w == OP_STANDBY |=> o_standby && !o_ins_ready)
    else $error("standby not entered");
  a_status_imm: assert property (
    go && w == OP_TEST_IMM |=> o_match == |($past(i_status) & $past(nib)))
    else $error("status match bit wrong");
  a_carry_fifteen: assert property (
    go && w == OP_CARRY15 |=> o_carry == ($past(o_acc) == NIB_15))
    else $error("carry for fifteen wrong");
  a_nop_only_pc: assert property (
    go && w == OP_NOP |=> o_pc == $past(o_pc) + 1'b1 && $stable(o_acc)
      && $stable(o_carry) && $stable(o_timer))
    else $error("no operation changed state");
  a_and_imm: assert property (
    go && w == 16'hfbf1 |=> o_acc == ($past(o_acc) & $past(nib))
      && o_carry == ($past(o_acc[3]) & $past(nib[3])))
    else $error("immediate and wrong");
  a_or_imm: assert property (
    go && w == 16'hfdf1 |=> o_acc == ($past(o_acc) | $past(nib)) && !o_carry)
    else $error("immediate or wrong");

  // Main scenarios reached
  c_ind_load: cover property (go && w == OP_T_IND);
  c_standby: cover property (go && w == OP_STANDBY);
  c_and_imm: cover property (go && w == 16'hfbf1);
endmodule : nib_core_assertions

bind nib_core nib_core_assertions #(.PC_W(PC_W)) i_chk (
  .i_clk(i_clk), .i_rst_n(i_rst_n), .i_ins_valid(i_ins_valid),
  .i_ins_word(i_ins_word), .i_ins_next(i_ins_next), .o_ins_ready(o_ins_ready),
  .i_status(i_status), .o_acc(o_acc), .o_carry(o_carry), .o_match(o_match),
  .o_standby(o_standby), .o_timer(o_timer), .o_pc(o_pc));

// file: tb/nib_core_tb.sv
`timescale 1ns/1ps
module nib_core_tb
  import nib_pkg::*;
;
  // Group codes in AND, OR, XOR order
  localparam logic [11:0] GRPS = {GRP_XOR, GRP_OR, GRP_AND};
  logic        i_clk, i_rst_n, i_ins_valid, i_rom_valid, i_read, i_write;
  logic [15:0] i_ins_word, i_ins_next;
  logic [9:0]  i_rom_data, o_timer;
  logic [3:0]  i_status, i_byteenable, o_acc;
  logic [7:0]  i_address;
  logic [31:0] i_writedata, o_readdata, rd;
  logic        o_ins_ready, o_rom_rd, o_waitrequest, o_carry, o_match, o_standby;
  logic [11:0] o_rom_addr;
  logic [10:0] o_pc;
  int          miscompares = 0;
  int          samples_checked = 0;
  int          cycles = 0;

  nib_core i_dut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_ins_valid(i_ins_valid),
    .i_ins_word(i_ins_word), .i_ins_next(i_ins_next), .o_ins_ready(o_ins_ready),
    .o_rom_rd(o_rom_rd), .o_rom_addr(o_rom_addr), .i_rom_valid(i_rom_valid),
    .i_rom_data(i_rom_data), .i_status(i_status), .i_address(i_address),
    .i_read(i_read), .i_write(i_write), .i_byteenable(i_byteenable),
    .i_writedata(i_writedata), .o_readdata(o_readdata), .o_waitrequest(o_waitrequest),
    .o_acc(o_acc), .o_carry(o_carry), .o_match(o_match), .o_standby(o_standby),
    .o_timer(o_timer), .o_pc(o_pc));

  // Free running 50 MHz clock
  initial begin
    i_clk = 1'b0;
    forever #10 i_clk = ~i_clk;
  end

  // Hang guard, far above the few hundred cycles the tests need
  always @(posedge i_clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      miscompares++;
      final_report();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  // Expected logic result, carry in bit 4
  function automatic logic [4:0] lg(input int g, input logic [3:0] a, input logic [3:0] b);
    case (g)
      0: return {a[3] & b[3], a & b};
      1: return {1'b0, a | b};
      default: return {a[3] & b[3], a ^ b};
    endcase
  endfunction : lg

  // Avalon cycle; request held until waitrequest is seen low at an edge
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clk);
    i_read <= !wr;
    i_write <= wr;
    i_address <= a;
    i_writedata <= d;
    i_byteenable <= 4'hf;
    // Waitrequest and read data are taken at the rising edge that completes
    do begin
      @(posedge i_clk);
    end while (o_waitrequest);
    rd = o_readdata;
    i_read <= 1'b0;
    i_write <= 1'b0;
  endtask : bus

  // Issue one instruction; answer a memory fetch if one is requested
  task automatic ins(input logic [15:0] wd, input logic [15:0] nx, input logic [9:0] rom);
    logic r;
    @(posedge i_clk);
    i_ins_valid <= 1'b1;
    i_ins_word <= wd;
    i_ins_next <= nx;
    do begin
      @(negedge i_clk);
      r = o_ins_ready;
      @(posedge i_clk);
    end while (!r);
    i_ins_valid <= 1'b0;
    @(negedge i_clk);
    if (o_rom_rd) begin
      @(posedge i_clk);
      i_rom_valid <= 1'b1;
      i_rom_data <= rom;
      @(posedge i_clk);
      i_rom_valid <= 1'b0;
      i_rom_data <= ~rom;
      @(negedge i_clk);
    end
  endtask : ins

  task automatic t_timer();
    logic [10:0] p;
    bus(1, REG_ACC, 32'h9);
    ins(OP_T0_FROM_A, 16'h0, 10'h0);
    bus(1, REG_ACC, 32'h16);
    ins(OP_T1_FROM_A, 16'h0, 10'h0);
    chk(o_timer[7:0], 8'h69);
    ins(OP_A_FROM_T0, 16'h0, 10'h0);
    chk({o_carry, o_acc}, 5'h09);
    bus(1, REG_ACC, 32'h10);
    ins(OP_A_FROM_T1, 16'h0, 10'h0);
    chk({o_carry, o_acc}, 5'h06);
    p = o_pc;
    ins(OP_T_IMM, 16'h02b7, 10'h0);
    chk(o_timer, 10'h2b7);
    chk(o_pc, p + 11'h2);
    bus(0, REG_TIMER, 32'h0);
    chk(rd, 32'h2b7);
    p = o_pc;
    ins(OP_NOP, 16'h0, 10'h0);
    chk({o_pc, o_timer, o_acc}, {p + 11'h1, 10'h2b7, 4'h6});
    bus(0, 8'hfc, 32'h0);
    chk(rd, 32'h0);
    $display("timer test done");
  endtask : t_timer

  task automatic t_logic();
    bus(1, 8'h4c, 32'h5e);
    for (int g = 0; g < 3; g++) begin
      for (int f = 0; f < 2; f++) begin
        bus(1, REG_ACC, 32'h9);
        ins({HI_TOP, GRPS[g*4 +: 4], f[0], LO_REG, 4'h3}, 16'h0, 10'h0);
        chk({o_carry, o_acc}, lg(g, 4'h9, f[0] ? 4'he : 4'h5));
      end
      bus(1, REG_ACC, 32'hc);
      ins({HI_TOP, GRPS[g*4 +: 4], 1'b1, LO_IMM}, 16'h000a, 10'h0);
      chk({o_carry, o_acc}, lg(g, 4'hc, 4'ha));
    end
    $display("logic test done");
  endtask : t_logic

  task automatic t_rom();
    bus(1, REG_CTRL, 32'h30);
    bus(1, 8'h40, 32'h21);
    for (int g = 0; g < 3; g++) begin
      for (int f = 0; f < 2; f++) begin
        bus(1, REG_ACC, 32'h9);
        ins({HI_TOP, GRPS[g*4 +: 4], f[0], LO_IND}, 16'h0, 10'h3c5);
        chk({o_carry, o_acc}, lg(g, 4'h9, f[0] ? 4'h5 : 4'hc));
      end
    end
    chk(o_rom_addr, 12'h321);
    ins(OP_T_IND, 16'h0, 10'h2d6);
    chk(o_timer, 10'h2d6);
    $display("memory test done");
  endtask : t_rom

  task automatic t_misc();
    @(posedge i_clk);
    i_status <= 4'h4;
    ins(OP_TEST_IMM, 16'h6, 10'h0);
    chk(o_match, 1'b1);
    ins(OP_TEST_IMM, 16'h3, 10'h0);
    chk(o_match, 1'b0);
    for (int v = 3; v < 5; v++) begin
      bus(1, 8'h4c, 32'(v));
      ins({OP_TEST_REG, 8'he3}, 16'h0, 10'h0);
      chk(o_match, v == 4);
    end
    for (int v = 14; v < 16; v++) begin
      bus(1, REG_ACC, 32'(v) | ((v == 14) ? 32'h10 : 32'h0));
      ins(OP_CARRY15, 16'h0, 10'h0);
      chk(o_carry, v == 15);
    end
    ins(OP_STANDBY, 16'h1, 10'h0);
    chk({o_standby, o_ins_ready}, 2'b10);
    bus(1, REG_CTRL, 32'h31);
    @(negedge i_clk);
    chk(o_standby, 1'b0);
    $display("misc test done");
  endtask : t_misc

  task automatic final_report();
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : final_report

  // Reset for three cycles, then the scenarios
  initial begin
    {i_rst_n, i_ins_valid, i_rom_valid, i_read, i_write} = 5'h0;
    {i_ins_word, i_ins_next, i_rom_data, i_status} = '0;
    {i_address, i_byteenable, i_writedata} = '0;
    repeat (3) @(posedge i_clk);
    i_rst_n <= 1'b1;
    repeat (4) @(posedge i_clk);
    t_timer();
    t_logic();
    t_rom();
    t_misc();
    final_report();
  end
endmodule : nib_core_tb
